// File: src/psf_status_word.sv
// processor status word register with flag update and bank select
//
// Operation
// - The status word lives at special register address 0xd0 and takes whole-byte and single-bit access.
// - Half carry is set on a carry into or borrow from the upper nibble.
// - Half carry is cleared by add, add with carry or subtract with borrow without a nibble carry or borrow; multiply and divide leave it.
// - User flags at bits 5 and 1 are freely software read/write and no instruction touches them.
// - Bank select bits 4:3 place register operands at bank times eight plus register number.
// - Overflow is set by add, add with carry or subtract with borrow on a signed overflow.
// - Overflow is set by multiply when the upper product byte is nonzero.
// - Overflow is set by divide with a zero divisor.
// - Overflow is cleared by those five instructions when no overflow condition occurs.
`timescale 1ns/100ps
module psf_status_word
(
   // clock and reset
   input  wire  logic                  CLOCK,
   input  wire  logic                  RST_N,
   input  wire  logic                  CLK_EN,
   // special register access
   input  wire  logic [7:0]            SFR_ADDR,
   input  wire  logic                  SFR_WR,
   input  wire  logic                  SFR_BIT,
   input  wire  logic [2:0]            SFR_BIT_SEL,
   input  wire  logic [7:0]            SFR_WDATA,
   output logic                        SFR_HIT,
   output logic [7:0]                  SFR_RDATA,
   // execution unit
   input  wire  psf_pkg::psf_alu_req_t ALU_REQ,
   input  wire  logic [7:0]            ACC_VALUE,
   // register operand mapping
   input  wire  logic [2:0]            REG_NUM,
   output logic [4:0]                  REG_ADDR,
   // flag outputs
   output logic                        CARRY_FLAG,
   output logic [1:0]                  REGISTER_BANK_SELECT
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0]             flags;
   logic [7:0]             next_flags;
   logic                   parity;
   psf_pkg::psf_flag_res_t calc;

   psf_flag_calc u_calc
   (
      .req   (ALU_REQ),
      .cy_in (flags[psf_pkg::POS_CARRY]),
      .res   (calc)
   );

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire       hit       = (SFR_ADDR == psf_pkg::FLAGS_ADDR);
   wire       wr_en     = hit && SFR_WR;
   wire [7:0] bit_mask  = 8'h01 << SFR_BIT_SEL;
   wire [7:0] wr_mask   = (SFR_BIT ? bit_mask : 8'hff) & psf_pkg::WRITE_MASK;
   wire [7:0] wr_val    = SFR_BIT ? {8{SFR_WDATA[0]}} : SFR_WDATA;

   assign parity = ^ACC_VALUE;

   // software write first, then instruction flags; a write in the same cycle
   // as an arithmetic result loses on the flags that the instruction updates
   always_comb
   begin
      next_flags = wr_en ? ((flags & ~wr_mask) | (wr_val & wr_mask)) : flags;
      if (calc.upd_cy)
      begin
         next_flags[psf_pkg::POS_CARRY] = calc.cy;
      end
      if (calc.upd_ac)
      begin
         next_flags[psf_pkg::POS_HALF] = calc.ac;
      end
      if (calc.upd_ov)
      begin
         next_flags[psf_pkg::POS_WRAP] = calc.ov;
      end
      next_flags[psf_pkg::POS_PARITY] = 1'b0;
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flags <= psf_pkg::FLAGS_RESET;
      end
      else if (CLK_EN)
      begin
         flags <= next_flags;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign SFR_HIT              = hit;
   assign SFR_RDATA            = {flags[7:1], parity};
   assign CARRY_FLAG           = flags[psf_pkg::POS_CARRY];
   assign REGISTER_BANK_SELECT = flags[psf_pkg::POS_BANK_HI:psf_pkg::POS_BANK_LO];
   assign REG_ADDR             = {REGISTER_BANK_SELECT, REG_NUM};

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   wire arith = CLK_EN && (ALU_REQ.op != psf_pkg::PSF_OP_NONE) && (ALU_REQ.op != psf_pkg::PSF_OP_MUL)
                && (ALU_REQ.op != psf_pkg::PSF_OP_DIV);

   a_addr_decode:  assert property (SFR_HIT == (SFR_ADDR == 8'hd0))        else $error("address decode wrong");
   a_half_carry:   assert property (arith && ALU_REQ.op == psf_pkg::PSF_OP_ADD
                      && ({1'b0, ALU_REQ.a[3:0]} + {1'b0, ALU_REQ.b[3:0]}) > 5'd15
                      |=> flags[6])                                         else $error("half carry not set");
   a_half_clear:   assert property (arith && ALU_REQ.op == psf_pkg::PSF_OP_ADD
                      && ({1'b0, ALU_REQ.a[3:0]} + {1'b0, ALU_REQ.b[3:0]}) <= 5'd15
                      |=> !flags[6])                                        else $error("half carry not cleared");
   a_user_kept:    assert property (!(CLK_EN && SFR_WR && SFR_HIT)
                      |=> $stable({flags[5], flags[1]}))                    else $error("user flag changed");
   a_bank_map:     assert property (REG_ADDR[4:3] == SFR_RDATA[4:3])        else $error("bank mapping wrong");
   a_add_wrap:     assert property (arith && ALU_REQ.op == psf_pkg::PSF_OP_ADD && ALU_REQ.a == 8'h7f
                      && ALU_REQ.b == 8'h01 |=> flags[2])                   else $error("add overflow missed");
   a_mul_wrap:     assert property (CLK_EN && ALU_REQ.op == psf_pkg::PSF_OP_MUL
                      |=> flags[2] == ($past(ALU_REQ.a) * $past(ALU_REQ.b) > 255)) else $error("mul overflow wrong");
   a_div_zero:     assert property (CLK_EN && ALU_REQ.op == psf_pkg::PSF_OP_DIV
                      |=> flags[2] == ($past(ALU_REQ.b) == 8'h00))          else $error("div overflow wrong");
   a_carry_add:    assert property (arith && ALU_REQ.op == psf_pkg::PSF_OP_ADD
                      |=> flags[7] == ($past(ALU_REQ.a) + $past(ALU_REQ.b) > 255)) else $error("carry wrong");
   a_parity_out:   assert property (SFR_RDATA[0] == ^ACC_VALUE)             else $error("parity wrong");

   c_bit_write:    cover property (CLK_EN && SFR_HIT && SFR_WR && SFR_BIT);
   c_mul_ovf:      cover property (CLK_EN && ALU_REQ.op == psf_pkg::PSF_OP_MUL ##1 flags[2]);
   c_bank_three:   cover property (REGISTER_BANK_SELECT == 2'b11);

endmodule

// File: src/psf_pkg.sv
// package for the processor status flags block
package psf_pkg;

   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [7:0] FLAGS_ADDR    = 8'hd0;
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam int         POS_CARRY     = 7;
   localparam int         POS_HALF      = 6;
   localparam int         POS_USER0     = 5;
   localparam int         POS_BANK_HI   = 4;
   localparam int         POS_BANK_LO   = 3;
   localparam int         POS_WRAP      = 2;
   localparam int         POS_USER1     = 1;
   localparam int         POS_PARITY    = 0;
   localparam logic [7:0] WRITE_MASK    = 8'hfe;
   localparam logic [2:0] BANK_BYTES_LOG = 3'h3;

   // ----------------------------------------
   // arithmetic operation codes
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      PSF_OP_NONE = 3'b000,
      PSF_OP_ADD  = 3'b001,
      PSF_OP_ADD_WITH_CARRY_INSTR = 3'b010,
      PSF_OP_SUBTRACT_BORROW_INSTR = 3'b011,
      PSF_OP_MUL  = 3'b100,
      PSF_OP_DIV  = 3'b101
   } psf_op_t;

   // operation request from the execution unit
   typedef struct packed
   {
      psf_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
   } psf_alu_req_t;

   // flag results computed for one operation
   typedef struct packed
   {
      logic upd_cy;
      logic upd_ac;
      logic upd_ov;
      logic cy;
      logic ac;
      logic ov;
   } psf_flag_res_t;

endpackage

// File: src/psf_flag_calc.sv
// flag computation for one arithmetic operation
`timescale 1ns/100ps
module psf_flag_calc
(
   // operation in
   input  wire  psf_pkg::psf_alu_req_t req,
   input  wire  logic                  cy_in,
   // flags out
   output wire  psf_pkg::psf_flag_res_t res
);

   wire        is_add  = (req.op == psf_pkg::PSF_OP_ADD) || (req.op == psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR);
   wire        is_sub  = (req.op == psf_pkg::PSF_OP_SUBTRACT_BORROW_INSTR);
   wire        is_mul  = (req.op == psf_pkg::PSF_OP_MUL);
   wire        is_div  = (req.op == psf_pkg::PSF_OP_DIV);
   wire        cin     = ((req.op == psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR) || is_sub) ? cy_in : 1'b0;
   wire [4:0]  lo_add  = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, cin};
   wire [4:0]  lo_sub  = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, cin};
   wire [8:0]  sum     = {1'b0, req.a} + {1'b0, req.b} + {8'h00, cin};
   wire [8:0]  dif     = {1'b0, req.a} - {1'b0, req.b} - {8'h00, cin};
   wire [15:0] prod    = req.a * req.b;
   wire        add_ov  = (req.a[7] == req.b[7]) && (sum[7] != req.a[7]);
   wire        sub_ov  = (req.a[7] != req.b[7]) && (dif[7] != req.a[7]);

   // mul and div leave carry and half carry to the core; only overflow is theirs here
   assign res.upd_cy = is_add || is_sub;
   assign res.upd_ac = is_add || is_sub;
   assign res.upd_ov = is_add || is_sub || is_mul || is_div;
   assign res.cy     = is_add ? sum[8] : dif[8];
   assign res.ac     = is_add ? lo_add[4] : lo_sub[4];
   assign res.ov     = is_add ? add_ov :
                       is_sub ? sub_ov :
                       is_mul ? (prod[15:8] != 8'h00) :
                       is_div ? (req.b == 8'h00) : 1'b0;

endmodule

// File: tb/tb_top.sv
// self-checking testbench for the processor status word block
`timescale 1ns/100ps
module tb_top;
   logic clk, rst_n, en, wr, bt, hit, cf, nrst;
   logic [7:0] addr, wd, rd, acc, model;
   logic [2:0] sel, rn;
   logic [4:0] ra;
   logic [1:0] bank;
   psf_pkg::psf_alu_req_t req;
   int error_cnt, comparisons;

   psf_status_word psf_status_word_inst (.CLOCK(clk), .RST_N(rst_n), .CLK_EN(en), .SFR_ADDR(addr), .SFR_WR(wr),
      .SFR_BIT(bt), .SFR_BIT_SEL(sel), .SFR_WDATA(wd), .SFR_HIT(hit), .SFR_RDATA(rd), .ALU_REQ(req),
      .ACC_VALUE(acc), .REG_NUM(rn), .REG_ADDR(ra), .CARRY_FLAG(cf), .REGISTER_BANK_SELECT(bank));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // flags expected after the edge that samples the present inputs
   function automatic logic [7:0] nxt(input logic [7:0] f);
      logic [8:0] s;
      logic       ci;
      ci = f[7] & (req.op != psf_pkg::PSF_OP_ADD);
      if (!rst_n) return 8'h00;
      if (!en) return f;
      if (wr && addr == psf_pkg::FLAGS_ADDR)
         if (!bt) f[7:1] = wd[7:1];
         else if (sel != 3'h0) f[sel] = wd[0];
      case (req.op)
         psf_pkg::PSF_OP_ADD, psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR:
         begin
            s = req.a + req.b + ci;
            f[7] = s[8];
            f[6] = (req.a[3:0] + req.b[3:0] + ci) > 5'h0f;
            f[2] = (req.a[7] == req.b[7]) && (s[7] != req.a[7]);
         end
         psf_pkg::PSF_OP_SUBTRACT_BORROW_INSTR:
         begin
            s = {1'b0, req.a} - req.b - ci;
            f[7] = s[8];
            f[6] = {1'b0, req.a[3:0]} < req.b[3:0] + ci;
            f[2] = (req.a[7] != req.b[7]) && (s[7] != req.a[7]);
         end
         psf_pkg::PSF_OP_MUL: f[2] = (req.a * req.b) > 16'h00ff;
         psf_pkg::PSF_OP_DIV: f[2] = req.b == 8'h00;
         default: ;
      endcase
      return f;
   endfunction

   task automatic chk(input string name, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input logic e, w, input logic [7:0] ad, d, input logic b, input logic [2:0] s,
                      input psf_pkg::psf_op_t op, input logic [7:0] a, bb);
      @(posedge clk);
      model = nxt(model);
      // carry-in order against a same-cycle write is left open, so keep those apart
      if (w && ad == psf_pkg::FLAGS_ADDR && (op == psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR || op == psf_pkg::PSF_OP_SUBTRACT_BORROW_INSTR))
         op = psf_pkg::PSF_OP_ADD;
      rst_n <= nrst;
      en <= e;
      wr <= w;
      addr <= ad;
      wd <= d;
      bt <= b;
      sel <= s;
      req <= '{op, a, bb};
      acc <= 8'($urandom);
      rn <= 3'($urandom);
      if (!nrst) model = 8'h00;
      @(negedge clk);
      chk("hit", {7'h00, hit}, {7'h00, addr == psf_pkg::FLAGS_ADDR});
      chk("rdata", rd, {model[7:1], ^acc});
      chk("reg_addr", {3'h0, ra}, {3'h0, model[4:3], rn});
      chk("carry", {7'h00, cf}, {7'h00, model[7]});
      chk("bank", {6'h00, bank}, {6'h00, model[4:3]});
   endtask

   task automatic op(input psf_pkg::psf_op_t o, input logic [7:0] a, b);
      cyc(1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, o, a, b);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #40000;
      error_cnt++;
      finish_test();
   end

   initial
   begin
      {rst_n, nrst, en, wr, bt, sel, addr, wd, acc, rn, model} = '0;
      req = '0;
      void'($urandom(32'h8243));
      repeat (5) op(psf_pkg::PSF_OP_NONE, 8'h00, 8'h00);
      nrst = 1'b1;
      for (int i = 0; i < 4; i++) cyc(1'b1, 1'b1, 8'hd0, {3'b111, 2'(i), 3'b111}, 1'b0, 3'h0, psf_pkg::PSF_OP_NONE, 8'h00, 8'h00);
      for (int i = 0; i < 16; i++) cyc(1'b1, 1'b1, 8'hd0, 8'(i & 1), 1'b1, 3'(i >> 1), psf_pkg::PSF_OP_NONE, 8'h00, 8'h00);
      cyc(1'b0, 1'b1, 8'hd0, 8'h00, 1'b0, 3'h0, psf_pkg::PSF_OP_MUL, 8'hff, 8'hff);
      op(psf_pkg::PSF_OP_ADD, 8'h7f, 8'h01);
      op(psf_pkg::PSF_OP_ADD, 8'h80, 8'h80);
      op(psf_pkg::PSF_OP_ADD_WITH_CARRY_INSTR, 8'hff, 8'h00);
      op(psf_pkg::PSF_OP_SUBTRACT_BORROW_INSTR, 8'h00, 8'h01);
      op(psf_pkg::PSF_OP_SUBTRACT_BORROW_INSTR, 8'h10, 8'h01);
      op(psf_pkg::PSF_OP_MUL, 8'h10, 8'h10);
      op(psf_pkg::PSF_OP_MUL, 8'h0f, 8'h11);
      op(psf_pkg::PSF_OP_DIV, 8'h05, 8'h00);
      op(psf_pkg::PSF_OP_DIV, 8'h05, 8'h03);
      $display("test directed done");
      nrst = 1'b0;
      op(psf_pkg::PSF_OP_ADD, 8'hff, 8'hff);
      nrst = 1'b1;
      op(psf_pkg::PSF_OP_NONE, 8'h00, 8'h00);
      $display("test reset done");
      repeat (3000) cyc($urandom_range(7) != 0, $urandom_range(2) == 0, $urandom_range(3) == 0 ? 8'($urandom) : 8'hd0,
         8'($urandom), 1'($urandom), 3'($urandom), psf_pkg::psf_op_t'($urandom_range(5)), 8'($urandom), 8'($urandom));
      $display("test random done");
      finish_test();
   end
endmodule
